// ==== logic/rml_decode.sv ====
// address claim decoder for the mode-dependent register map
`timescale 1ns/1ps
`default_nettype none
module rml_decode
    import rml_pkg::*;
(
    // map state
    input  wire logic [2:0] mode,
    input  wire logic       port_e_emulation_enable,
    input  wire logic       port_k_emulation_enable,
    // address
    input  wire logic [9:0] addr,
    // result
    output logic            hit_ab,
    output logic            hit_e,
    output logic            hit_k,
    output logic            hit_mode
);
    logic exp;
    logic per;
    logic a_ab;
    logic a_e;
    logic a_k;

    // address groups
    always_comb
    begin
        exp  = rml_is_expanded(mode);
        per  = rml_is_periph(mode);
        a_ab = (addr == REG_PORTA) || (addr == REG_PORTB)
            || (addr == REG_PORT_A_DIRECTION_REG) || (addr == REG_PORT_B_DIRECTION_REG);
        a_e  = (addr == REG_PORTE) || (addr == REG_PORT_E_DIRECTION_REG);
        a_k  = (addr == REG_PORTK) || (addr == REG_PORT_K_DIRECTION_REG);
    end

    // visibility per mode
    assign hit_ab   = a_ab && !exp && !per;
    assign hit_e    = a_e && !per && !(exp && port_e_emulation_enable);
    assign hit_k    = a_k && !per && !(exp && port_k_emulation_enable);
    assign hit_mode = (addr == REG_MODE) && !per;
endmodule
`default_nettype wire

// ==== logic/rml_pkg.sv ====
// package: constants, types and behaviour list for the reset mode latch
//
// Behaviour
// - operating mode comes from debug and mode strap levels held during reset
// - strap levels captured into mode flag and bits as reset releases
// - code decodes to eight modes; 110 is forced to peripheral
// - each mode selects memory map and port A/B bus roles
// - software may relocate internal resources through mapping registers
// - expanded modes send unclaimed addresses to external memory
// - expanded and peripheral modes hide port A/B data and direction
// - port E hidden in peripheral, or expanded with port E emulation set
// - port K hidden in peripheral, or expanded with port K emulation set
// - reserved or unmapped reads return no defined value
// - normal modes restrict writes to protected control bits
// - special modes relax protection for test and emulation
// - special single chip enters debug monitor right after reset
// - background debug is available in every mode; code has only the debug monitor, on from reset in special single chip
// - mode bits report the mode and allow limited run-time change
// - special flag always readable, writable only in special, first ignored; code hides it in peripheral mode, where reads give FF
// - mode bits write once in normal, anytime but the first in special, no peripheral
// - peripheral mode entered or left only through reset
package rml_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [9:0] REG_MODE   = 10'h00B;
    localparam logic [9:0] REG_MAP    = 10'h010;
    localparam logic [9:0] REG_PORTA  = 10'h000;
    localparam logic [9:0] REG_PORTB  = 10'h001;
    localparam logic [9:0] REG_PORT_A_DIRECTION_REG   = 10'h002;
    localparam logic [9:0] REG_PORT_B_DIRECTION_REG   = 10'h003;
    localparam logic [9:0] REG_PORTE  = 10'h008;
    localparam logic [9:0] REG_PORT_E_DIRECTION_REG   = 10'h009;
    localparam logic [9:0] REG_PORTK  = 10'h0FC;
    localparam logic [9:0] REG_PORT_K_DIRECTION_REG   = 10'h0FD;

    // ------------------------------------------------------------
    // mode register field positions
    // ------------------------------------------------------------
    localparam int BIT_SPECIAL_MODE_LOW_FLAG = 7;
    localparam int BIT_MODE_STRAP_B  = 6;
    localparam int BIT_MODE_STRAP_A  = 5;
    localparam int BIT_EMK   = 1;
    localparam int BIT_EME   = 0;

    localparam logic [7:0] UNDEF_READ = 8'hFF;
    localparam logic [7:0] MAP_RESET  = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;

    // ------------------------------------------------------------
    // mode codes {debug, b, a}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SSC  = 3'h0,
        MODE_SNAR = 3'h1,
        MODE_SPER = 3'h2,
        MODE_SWID = 3'h3,
        MODE_NSC  = 3'h4,
        MODE_NNAR = 3'h5,
        MODE_NRSV = 3'h6,
        MODE_NWID = 3'h7
    } rml_mode_t;

    typedef enum logic [1:0] {
        BUS_GPIO,
        BUS_NARROW,
        BUS_WIDE
    } rml_bus_t;

    // register port request
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rml_req_t;

    // block state
    typedef struct packed {
        logic [2:0] mode;
        logic       armed;
        logic       first_done;
        logic       ab_written;
        logic       port_e_emulation_enable;
        logic       port_k_emulation_enable;
        logic [7:0] map_ctl;
        logic [7:0] porta;
        logic [7:0] portb;
        logic [7:0] port_a_direction_reg;
        logic [7:0] port_b_direction_reg;
        logic [7:0] porte;
        logic [7:0] port_e_direction_reg;
        logic [7:0] portk;
        logic [7:0] port_k_direction_reg;
        logic [7:0] rdata;
        logic       debug_active;
        logic       external_sel;
        logic [1:0] bus_cfg;
        logic       special;
    } rml_state_t;

    // mode of a strap code; reserved is forced to peripheral
    function automatic logic [2:0] rml_fix_code(input logic [2:0] c);
        rml_fix_code = (c == MODE_NRSV) ? MODE_SPER : c;
    endfunction

    function automatic logic rml_is_expanded(input logic [2:0] c);
        rml_is_expanded = (c[1:0] != 2'h0) && (c != MODE_SPER);
    endfunction

    function automatic logic rml_is_periph(input logic [2:0] c);
        rml_is_periph = (c == MODE_SPER);
    endfunction

endpackage

// ==== logic/rml_top.sv ====
// reset mode latch with mode register and port visibility control
`timescale 1ns/1ps
`default_nettype none
module rml_top
    import rml_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // strap pins
    input  wire logic       debug_strap_pin,
    input  wire logic       mode_strap_b,
    input  wire logic       mode_strap_a,
    // register port
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // mode status
    output logic [2:0]      mode_code,
    output logic            special_mode,
    output logic [1:0]      bus_config,
    output logic            debug_monitor_mode,
    output logic            external_access,
    output logic [7:0]      map_control
);
    rml_state_t st;
    rml_state_t next_st;
    rml_req_t   req;
    logic       hit_ab;
    logic       hit_e;
    logic       hit_k;
    logic       hit_mode;
    logic [2:0] strap;
    logic [2:0] wr_code;
    logic       do_wr;
    logic       first_wr;

    assign req   = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                     rd: reg_rd};
    assign strap = {debug_strap_pin, mode_strap_b, mode_strap_a};

    // which registers the current mode exposes
    rml_decode u_dec (
        .mode     (st.mode),
        .port_e_emulation_enable      (st.port_e_emulation_enable),
        .port_k_emulation_enable      (st.port_k_emulation_enable),
        .addr     (req.addr),
        .hit_ab   (hit_ab),
        .hit_e    (hit_e),
        .hit_k    (hit_k),
        .hit_mode (hit_mode)
    );

    // bus role of ports a and b for a mode
    function automatic logic [1:0] bus_of(input logic [2:0] c);
        logic [1:0] r;
        r = BUS_WIDE;
        if (c[1:0] == 2'h0)
            r = BUS_GPIO;
        else if (c[1:0] == 2'h1)
            r = BUS_NARROW;
        bus_of = r;
    endfunction

    // next state
    always_comb
    begin
        next_st  = st;
        do_wr    = req.wr && hit_mode;
        first_wr = do_wr && !st.first_done;
        wr_code  = st.mode;
        // strap capture: first clock after reset release, while the
        // straps still hold the reset-time level on the board
        if (!st.armed)
        begin
            next_st.armed = 1'b1;
            next_st.mode  = rml_fix_code(strap);
            next_st.debug_active = (rml_fix_code(strap) == MODE_SSC);
            next_st.port_e_emulation_enable = !strap[2];
            next_st.port_k_emulation_enable = !strap[2];
        end
        else if (do_wr)
        begin
            next_st.first_done = 1'b1;
            // special flag: only in special modes, first write dropped
            if (!st.mode[2] && !first_wr)
                wr_code[2] = req.wdata[BIT_SPECIAL_MODE_LOW_FLAG];
            // a/b bits: once in normal, any time but the first in special
            if (st.mode[2] && !st.ab_written)
            begin
                wr_code[1] = req.wdata[BIT_MODE_STRAP_B];
                wr_code[0] = req.wdata[BIT_MODE_STRAP_A];
                next_st.ab_written = 1'b1;
            end
            else if (!st.mode[2] && !first_wr)
            begin
                wr_code[1] = req.wdata[BIT_MODE_STRAP_B];
                wr_code[0] = req.wdata[BIT_MODE_STRAP_A];
            end
            // never reach peripheral or reserved by software
            if (wr_code[1:0] != 2'h2 && st.mode != MODE_SPER)
                next_st.mode = wr_code;
            // emulation enables: any write in special modes, first write only in normal
            if (!st.mode[2] || !st.first_done)
            begin
                next_st.port_e_emulation_enable = req.wdata[BIT_EME];
                next_st.port_k_emulation_enable = req.wdata[BIT_EMK];
            end
        end
        // mapping control for relocation
        if (st.armed && req.wr && req.addr == REG_MAP
            && !rml_is_periph(st.mode))
            next_st.map_ctl = req.wdata;
        // port registers only when visible
        if (req.wr && hit_ab)
        begin
            if (req.addr == REG_PORTA) next_st.porta = req.wdata;
            if (req.addr == REG_PORTB) next_st.portb = req.wdata;
            if (req.addr == REG_PORT_A_DIRECTION_REG)  next_st.port_a_direction_reg  = req.wdata;
            if (req.addr == REG_PORT_B_DIRECTION_REG)  next_st.port_b_direction_reg  = req.wdata;
        end
        if (req.wr && hit_e)
        begin
            if (req.addr == REG_PORTE) next_st.porte = req.wdata;
            if (req.addr == REG_PORT_E_DIRECTION_REG)  next_st.port_e_direction_reg  = req.wdata;
        end
        if (req.wr && hit_k)
        begin
            if (req.addr == REG_PORTK) next_st.portk = req.wdata;
            if (req.addr == REG_PORT_K_DIRECTION_REG)  next_st.port_k_direction_reg  = req.wdata;
        end
        // read data, one cycle after the strobe; holes give a filler
        next_st.rdata = UNDEF_READ;
        if (!req.rd)
            next_st.rdata = 8'h00;
        else if (hit_mode)
            next_st.rdata = {st.mode, 3'h0, st.port_k_emulation_enable, st.port_e_emulation_enable};
        else if (req.addr == REG_MAP && !rml_is_periph(st.mode))
            next_st.rdata = st.map_ctl;
        else if (hit_ab)
        begin
            if (req.addr == REG_PORTA)      next_st.rdata = st.porta;
            else if (req.addr == REG_PORTB) next_st.rdata = st.portb;
            else if (req.addr == REG_PORT_A_DIRECTION_REG)  next_st.rdata = st.port_a_direction_reg;
            else                            next_st.rdata = st.port_b_direction_reg;
        end
        else if (hit_e)
            next_st.rdata = (req.addr == REG_PORTE) ? st.porte : st.port_e_direction_reg;
        else if (hit_k)
            next_st.rdata = (req.addr == REG_PORTK) ? st.portk : st.port_k_direction_reg;
        // debug facility: on from reset in ssc only, cleared by a write that sets normal
        if (do_wr && !st.mode[2] && !first_wr
            && req.wdata[BIT_SPECIAL_MODE_LOW_FLAG])
            next_st.debug_active = 1'b0;
        // derived outputs follow the latched code
        next_st.special      = !next_st.mode[2];
        next_st.bus_cfg      = bus_of(next_st.mode);
        next_st.external_sel = rml_is_expanded(next_st.mode);
    end

    // state register; strap capture waits for release, so reset
    // loads constants only and later strap motion is ignored
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.rdata <= 8'h00;
            st.map_ctl <= MAP_RESET;
        end
        else
            st <= next_st;
    end

    // outputs straight from flip-flops
    assign reg_rdata          = st.rdata;
    assign mode_code          = st.mode;
    assign special_mode       = st.special;
    assign bus_config         = st.bus_cfg;
    assign debug_monitor_mode = st.debug_active;
    assign external_access    = st.external_sel;
    assign map_control        = st.map_ctl;
endmodule
`default_nettype wire

// ==== sim/rml_strap_model.sv ====
// board strap model: resistor levels on the three mode pins
`timescale 1ns/1ps
`default_nettype none
module rml_strap_model
(
    // board code {debug, b, a}
    input  wire logic [2:0] code,
    // strap pins
    output logic            debug_strap_pin,
    output logic            mode_strap_b,
    output logic            mode_strap_a
);
    // plain levels; bench holds code steady across reset release
    assign debug_strap_pin = code[2];
    assign mode_strap_b    = code[1];
    assign mode_strap_a    = code[0];
endmodule
`default_nettype wire

// ==== sim/rml_top_asserts.sv ====
// assertion checker bound to the reset mode latch top
`timescale 1ns/1ps
`default_nettype none
module rml_top_asserts
    import rml_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // register port
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // mode status
    input wire logic [2:0] mode_code,
    input wire logic       special_mode,
    input wire logic [1:0] bus_config,
    input wire logic       debug_monitor_mode,
    input wire logic       external_access,
    input wire logic [7:0] map_control
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic       live;
    logic [1:0] bus_exp;

    // live from the strap latch edge on; outputs before it are reset values
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            live <= 1'b0;
        else
            live <= 1'b1;
    end

    // expected bus role from the low code bits
    assign bus_exp = (mode_code[1:0] == 2'h0) ? 2'h0 :
                     (mode_code[1:0] == 2'h1) ? 2'h1 : 2'h2;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_SPECIAL: assert property (live |-> special_mode == !mode_code[2])
        else $error("special flag disagrees with mode code");
    AST_NORSV: assert property (live |-> mode_code != 3'h6)
        else $error("reserved mode code visible");
    AST_BUS: assert property (live |-> bus_config == bus_exp)
        else $error("bus role disagrees with mode code");
    AST_EXT: assert property (live |-> external_access ==
        (mode_code[1:0] != 2'h0 && mode_code != 3'h2))
        else $error("external routing wrong for mode");
    AST_DBG: assert property (live && !$past(live) |->
        debug_monitor_mode == (mode_code == 3'h0))
        else $error("debug monitor state wrong after reset");
    AST_HOLD: assert property (live && $past(live) && $changed(mode_code)
        |-> $past(reg_wr) && $past(reg_addr) == REG_MODE)
        else $error("mode changed without a mode write");
    AST_PER: assert property (live && $past(live) |->
        (mode_code == 3'h2) == ($past(mode_code) == 3'h2))
        else $error("peripheral mode entered or left by write");
    AST_NOSPEC: assert property (live && $past(live) &&
        $past(mode_code[2]) |-> mode_code[2])
        else $error("normal mode turned special by write");
    AST_UNMAP: assert property (reg_rd && reg_addr[9:8] != 2'h0
        |=> reg_rdata == 8'hFF)
        else $error("unmapped read value wrong");
    AST_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_MAP: assert property (reg_wr && reg_addr == REG_MAP
        |=> map_control == $past(reg_wdata))
        else $error("map control not written");

    // main scenarios
    CV_DBG: cover property (live && debug_monitor_mode);
    CV_SPX: cover property (live && special_mode && external_access);
    CV_SW: cover property (live && $past(live) && $changed(mode_code));
endmodule

bind rml_top rml_top_asserts u_asserts (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_code(mode_code),
    .special_mode(special_mode), .bus_config(bus_config),
    .debug_monitor_mode(debug_monitor_mode),
    .external_access(external_access), .map_control(map_control)
);
`default_nettype wire

// ==== sim/rml_top_test.sv ====
// self-checking bench for the reset mode latch
`timescale 1ns/1ps
`default_nettype none
module rml_top_test;
    import rml_pkg::*;
    logic       sys_clk, nrst, ds, mb, ma, reg_wr, reg_rd;
    logic       special_mode, debug_monitor_mode, external_access;
    logic [2:0] code, mode_code;
    logic [1:0] bus_config;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, map_control;
    int         errors, n_tests, cycles;

    rml_strap_model u_strap (.code(code), .debug_strap_pin(ds),
        .mode_strap_b(mb), .mode_strap_a(ma));
    rml_top dut (.sys_clk(sys_clk), .nrst(nrst), .debug_strap_pin(ds),
        .mode_strap_b(mb), .mode_strap_a(ma), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode_code(mode_code),
        .special_mode(special_mode), .bus_config(bus_config),
        .debug_monitor_mode(debug_monitor_mode),
        .external_access(external_access), .map_control(map_control));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task summarize;
    begin
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // one-cycle write; a gap edge follows so strobes never overlap
    task wr(input logic [9:0] a, input logic [7:0] d);
    begin
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [9:0] a, input logic [7:0] e);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    end
    endtask

    // straps held through release and the latch edge
    task rst(input logic [2:0] c);
    begin
        @(posedge sys_clk);
        nrst <= 1'b0;
        code <= c;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
    end
    endtask

    // ----------------------------------------
    // clock, timeout, stimulus
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // whole run is well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            summarize();
        end
    end

    initial
    begin
        logic [2:0] f;
        logic       sp, ex, hid;
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        code = 3'h4;
        // every strap code, each behind a fresh reset
        for (int i = 0; i < 8; i++)
        begin
            rst(i[2:0]);
            code <= ~i[2:0];
            f = (i == 6) ? 3'h2 : i[2:0];
            sp = !f[2];
            ex = f[1:0] != 2'h0 && f != 3'h2;
            hid = f == 3'h2 || (ex && sp);
            chk({5'h0, mode_code}, {5'h0, f});
            chk({7'h0, special_mode}, {7'h0, sp});
            chk({6'h0, bus_config}, (f[1:0] == 2'h0) ? 8'h0 :
                (f[1:0] == 2'h1) ? 8'h1 : 8'h2);
            chk({7'h0, external_access}, {7'h0, ex});
            chk({7'h0, debug_monitor_mode}, {7'h0, f == 3'h0});
            chk(map_control, 8'h00);
            if (f != 3'h2)
                rd(REG_MODE, {f, 3'h0, sp, sp});
            rd(REG_PORTA, (f[1:0] == 2'h0) ? 8'h00 : 8'hFF);
            rd(REG_PORT_B_DIRECTION_REG, (f[1:0] == 2'h0) ? 8'h00 : 8'hFF);
            rd(REG_PORTE, hid ? 8'hFF : 8'h00);
            rd(REG_PORT_K_DIRECTION_REG, hid ? 8'hFF : 8'h00);
            rd(10'h3FF, 8'hFF);
            chk({5'h0, mode_code}, {5'h0, f});
        end
        // normal single chip: one mode write, then a/b and emulation bits locked
        rst(3'h4);
        wr(REG_PORTA, 8'h5A);
        rd(REG_PORTA, 8'h5A);
        wr(REG_MODE, 8'h21);
        chk({5'h0, mode_code}, 8'h05);
        chk({6'h0, bus_config}, 8'h01);
        rd(REG_PORTA, 8'hFF);
        rd(REG_PORTE, 8'hFF);
        rd(REG_PORTK, 8'h00);
        wr(REG_MODE, 8'hE2);
        rd(REG_MODE, 8'hA1);
        // special single chip: first write keeps the mode bits, then free
        rst(3'h0);
        wr(REG_MAP, 8'h5A);
        chk(map_control, 8'h5A);
        rd(REG_MAP, 8'h5A);
        wr(REG_MODE, 8'h63);
        chk({5'h0, mode_code}, 8'h00);
        wr(REG_MODE, 8'h63);
        chk({5'h0, mode_code}, 8'h03);
        rd(REG_PORTK, 8'hFF);
        wr(REG_MODE, 8'h43);
        chk({5'h0, mode_code}, 8'h03);
        wr(REG_MODE, 8'h23);
        chk({6'h0, bus_config}, 8'h01);
        wr(REG_MODE, 8'hA3);
        chk({7'h0, special_mode}, 8'h00);
        wr(REG_MODE, 8'h63);
        chk({5'h0, mode_code}, 8'h07);
        // peripheral cannot be left by writes
        rst(3'h2);
        wr(REG_MODE, 8'h63);
        wr(REG_MODE, 8'h63);
        chk({5'h0, mode_code}, 8'h02);
        summarize();
    end
endmodule
`default_nettype wire
